// *** logic/strobe_iface_pkg.sv ***
// Purpose: Shared constants and types of the strobe bus interface.
// Assumes: One byte moves per rising edge of the bus clock.
// Notes: Kinds tag each byte that is handed to the system side.
package strobe_iface_pkg;
  localparam int CA_BYTES = 6;
  localparam int CA_CNT_W = 3;
  localparam int CA_DIR_BIT = 7;
  localparam int LATENCY_CLOCKS = 4;
  localparam int LAT_CNT_W = 8;
  localparam int EV_W = 11;
  localparam logic [1:0] KIND_CA = 2'h1;
  localparam logic [1:0] KIND_WR = 2'h2;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [1:0] {ST_CMD, ST_LAT, ST_RDATA, ST_WDATA} link_state_e;
endpackage

// *** logic/pair_buffer.sv ***
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Full and empty follow the entry count exactly.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } buf_s;

  buf_s q;
  buf_s d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 2'h1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// *** logic/strobe_iface.sv ***
// Purpose: Device-side bus interface with the centred read strobe.
// Assumes: Link logic runs on the bus clock, user side on clk_sys.
// Notes: Read bytes are fetched one link cycle ahead of launch; the first is fetched at the last command-address byte.
//
// Operation
// - Select falling starts, rising ends a transaction
// - Bytes sampled and launched on bus clock
// - Data lines carry command-address then data
// - Option present: strobe timed from shifted clock
// - Each shifted clock transition moves the strobe
// - Shifted clock ignored during writes
// - Writes: strobe becomes host-driven byte mask
// - Strobe reports extra latency at transaction start
// - Reset low: idle, strobe and data released
// - Error output flags ECC events
`timescale 1ns/1ps
`default_nettype none
module strobe_iface #(
  parameter int LAT_CLOCKS = strobe_iface_pkg::LATENCY_CLOCKS
) (
  // System clock and hardware reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus clocks from the host
  input wire logic bus_clock,
  input wire logic bus_clock_bar,
  input wire logic phase_shift_clock,
  input wire logic phase_shift_clock_bar,
  // Select, active low
  input wire logic select_b,
  // Data lines
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  // Read-write strobe and mask
  input wire logic rw_data_strobe_in,
  output logic rw_data_strobe_out,
  output logic rw_data_strobe_oe,
  // Strap and latency request
  input wire logic centered_read_strobe_option,
  input wire logic addl_latency,
  // Received byte stream
  output logic ev_valid,
  input wire logic ev_ready,
  output logic [strobe_iface_pkg::EV_W-1:0] ev_data,
  // Read byte supply
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data,
  // Error indication
  input wire logic ecc_event,
  input wire logic err_clear,
  output logic err_out
);
  import strobe_iface_pkg::*;

  typedef struct packed {
    link_state_e st;
    logic [CA_CNT_W-1:0] ca_cnt;
    logic is_read;
    logic [LAT_CNT_W-1:0] lat_cnt;
    logic dq_oe;
    logic [7:0] dq_out;
  } link_s;

  // Hand-off state lives outside the frame reset
  typedef struct packed {
    logic ev_tog;
    logic [EV_W-1:0] ev_word;
    logic req_tog;
  } hand_s;

  typedef struct packed {
    logic addl_s1;
    logic addl_s2;
  } lsync_s;

  typedef struct packed {
    logic [1:0] strap_cnt;
    logic opt_s1;
    logic opt;
    logic addl;
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic pend;
    logic [EV_W-1:0] pend_word;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic [7:0] rd_byte;
    logic err;
  } sys_s;

  localparam logic [LAT_CNT_W-1:0] LAT_ONE = LAT_CNT_W'(LAT_CLOCKS);
  localparam logic [LAT_CNT_W-1:0] LAT_TWO = LAT_CNT_W'(2 * LAT_CLOCKS);
  localparam logic [CA_CNT_W-1:0] CA_LAST = CA_CNT_W'(CA_BYTES - 1);

  link_s lq;
  link_s ld;
  hand_s hq;
  hand_s hd;
  lsync_s sq;
  sys_s yq;
  sys_s yd;
  logic link_rst_b;
  logic frame_on;
  logic buf_in_ready;

  ////////////////////////////////////////////////////////////////////
  // Link side

  // Raised select ends the frame even with the bus clock stopped
  assign link_rst_b = rst_b && !select_b;
  assign frame_on = rst_b && !select_b;

  always_comb begin
    ld = lq;
    hd = hq;
    case (lq.st)
      ST_CMD: begin
        hd.ev_word = {KIND_CA, 1'b0, dq_in};
        hd.ev_tog = ~hq.ev_tog;
        ld.ca_cnt = lq.ca_cnt + CA_CNT_W'(1);
        if (lq.ca_cnt == '0) begin
          ld.is_read = dq_in[CA_DIR_BIT];
        end
        if (lq.ca_cnt == CA_LAST) begin
          ld.st = ST_LAT;
          ld.lat_cnt = sq.addl_s2 ? LAT_TWO : LAT_ONE;
          if (lq.is_read) begin
            // Prefetch the first read byte during latency
            hd.req_tog = ~hq.req_tog;
          end
        end
      end
      ST_LAT: begin
        ld.lat_cnt = lq.lat_cnt - LAT_CNT_W'(1);
        if (lq.lat_cnt == LAT_CNT_W'(1)) begin
          if (lq.is_read) begin
            ld.st = ST_RDATA;
            ld.dq_oe = 1'b1;
            ld.dq_out = yq.rd_byte;
            hd.req_tog = ~hq.req_tog;
          end else begin
            ld.st = ST_WDATA;
          end
        end
      end
      ST_RDATA: begin
        // Fetched byte settles within a few system clocks, well under a link cycle
        ld.dq_out = yq.rd_byte;
        hd.req_tog = ~hq.req_tog;
      end
      ST_WDATA: begin
        hd.ev_word = {KIND_WR, rw_data_strobe_in, dq_in};
        hd.ev_tog = ~hq.ev_tog;
      end
      default: begin
        ld.st = ST_CMD;
      end
    endcase
  end

  always_ff @(posedge bus_clock or negedge link_rst_b) begin
    if (!link_rst_b) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Hand-off between the link and system sides

  // A raised select must not clear the toggles, or a false word would cross
  always_ff @(posedge bus_clock or negedge rst_b) begin
    if (!rst_b) begin
      hq <= '0;
    end else if (!select_b) begin
      hq <= hd;
    end
  end
  // Read byte is a held word: it settles a few system clocks after the
  // request and the link samples it one link period later

  // Latency request crosses as a level; held across frames
  always_ff @(posedge bus_clock or negedge rst_b) begin
    if (!rst_b) begin
      sq <= '0;
    end else begin
      sq.addl_s1 <= yq.addl;
      sq.addl_s2 <= sq.addl_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pins

  assign dq_out = lq.dq_out;
  assign dq_oe = frame_on && lq.dq_oe;

  // Strobe driven at start, in reads; released in writes
  always_comb begin
    rw_data_strobe_oe = 1'b0;
    rw_data_strobe_out = 1'b0;
    if (frame_on) begin
      if (lq.st == ST_CMD || lq.st == ST_LAT) begin
        rw_data_strobe_oe = 1'b1;
        rw_data_strobe_out = sq.addl_s2;
      end else if (lq.st == ST_RDATA) begin
        rw_data_strobe_oe = 1'b1;
        // Strap is static, so switching the clock source here is safe
        if (yq.opt) begin
          rw_data_strobe_out = phase_shift_clock;
        end else begin
          rw_data_strobe_out = bus_clock;
        end
      end
    end
  end
  // Complement clocks only shape the pad receivers; no logic reads them
  // Write state never selects the shifted clock
  // Writes leave the strobe released for the host mask

  ////////////////////////////////////////////////////////////////////
  // System side

  always_comb begin
    yd = yq;
    yd.opt_s1 = centered_read_strobe_option;
    // Strap passes two flops, then stays frozen for the run
    if (yq.strap_cnt != 2'h2) begin
      yd.strap_cnt = yq.strap_cnt + 2'h1;
      yd.opt = yq.opt_s1;
    end
    yd.addl = addl_latency;
    // Toggles pass two flops; the third one finds the edge
    yd.ev_s1 = hq.ev_tog;
    yd.ev_s2 = yq.ev_s1;
    yd.ev_s3 = yq.ev_s2;
    yd.req_s1 = hq.req_tog;
    yd.req_s2 = yq.req_s1;
    yd.req_s3 = yq.req_s2;
    // Word held here until the buffer takes it
    if (yq.pend && buf_in_ready) begin
      yd.pend = 1'b0;
    end
    if (yq.ev_s2 != yq.ev_s3) begin
      yd.pend = 1'b1;
      // Word has stood still since its toggle left the link
      yd.pend_word = hq.ev_word;
    end
    if (yq.req_s2 != yq.req_s3) begin
      // Underrun sends a filler byte rather than stalling the bus
      yd.rd_byte = rd_valid ? rd_data : IDLE_BYTE;
    end
    if (err_clear) begin
      yd.err = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (ecc_event) begin
      yd.err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      yq <= '0;
    end else begin
      yq <= yd;
    end
  end

  assign rd_ready = (yq.req_s2 != yq.req_s3);
  assign err_out = yq.err;

  ////////////////////////////////////////////////////////////////////
  // Output buffer

  pair_buffer #(
    .WIDTH(EV_W)
  ) u_ev_buf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(yq.pend),
    .in_ready(buf_in_ready),
    .in_data(yq.pend_word),
    .out_valid(ev_valid),
    .out_ready(ev_ready),
    .out_data(ev_data)
  );
endmodule
`default_nettype wire

// *** test/strobe_iface_sva.sv ***
// Purpose: Port checks of the strobe bus interface.
// Assumes: Sampled on clk_sys; link pins seen as levels.
// Notes: Bound to every strobe_iface instance.
`timescale 1ns/1ps
`default_nettype none
module strobe_iface_sva
  import strobe_iface_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Link side
  input wire logic bus_clock,
  input wire logic phase_shift_clock,
  input wire logic select_b,
  input wire logic dq_oe,
  input wire logic rw_data_strobe_out,
  input wire logic rw_data_strobe_oe,
  input wire logic centered_read_strobe_option,
  // System side
  input wire logic ev_valid,
  input wire logic [EV_W-1:0] ev_data,
  input wire logic rd_ready,
  input wire logic ecc_event,
  input wire logic err_clear,
  input wire logic err_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property ($rose(rst_b) |-> !dq_oe && !rw_data_strobe_oe && !err_out)
    else $error("outputs active after reset");
  a_idle_quiet: assert property (select_b |-> !dq_oe && !rw_data_strobe_oe)
    else $error("driving while deselected");
  a_start_flag: assert property ($fell(select_b) |-> rw_data_strobe_oe)
    else $error("no latency flag at start");
  a_read_pair: assert property (dq_oe |-> rw_data_strobe_oe && !select_b)
    else $error("data without strobe");
  a_shift_follow: assert property (dq_oe && centered_read_strobe_option |->
    rw_data_strobe_out == phase_shift_clock)
    else $error("strobe not on shifted clock");
  a_clock_follow: assert property (dq_oe && !centered_read_strobe_option |->
    rw_data_strobe_out == bus_clock)
    else $error("strobe not on bus clock");
  a_write_mask: assert property ($rose(ev_valid) && ev_data[10:9] == KIND_WR |->
    !rw_data_strobe_oe)
    else $error("strobe driven in write");
  a_fetch_pulse: assert property (rd_ready |=> !rd_ready)
    else $error("fetch pulse too long");
  a_err_set: assert property (ecc_event |=> err_out)
    else $error("error not raised");
  a_err_clear: assert property (err_clear && !ecc_event |=> !err_out)
    else $error("error not cleared");
endmodule
bind strobe_iface strobe_iface_sva sva_i (.clk_sys, .rst_b, .bus_clock, .phase_shift_clock,
  .select_b, .dq_oe, .rw_data_strobe_out, .rw_data_strobe_oe, .centered_read_strobe_option,
  .ev_valid, .ev_data, .rd_ready, .ecc_event, .err_clear, .err_out);
`default_nettype wire

// *** test/host_model.sv ***
// Purpose: Bus host that frames transfers.
// Assumes: One byte per bus clock rise; clock idles low.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Host-driven pins
  output logic bus_clock,
  output logic bus_clock_bar,
  output logic phase_shift_clock,
  output logic phase_shift_clock_bar,
  output logic select_b,
  output logic [7:0] dq_host,
  output logic mask_out,
  // Device data
  input wire logic [7:0] dq_out
);
  import strobe_iface_pkg::*;
  logic wr_q = 1'b0;
  logic [10:0] exp_ev[$];
  logic [7:0] got_rd[$];
  initial begin
    bus_clock = 1'b0;
    phase_shift_clock = 1'b0;
    select_b = 1'b1;
    dq_host = 8'h00;
    mask_out = 1'b0;
  end
  assign bus_clock_bar = ~bus_clock;
  // Quarter period late; frozen in writes
  always @(bus_clock) if (!wr_q) phase_shift_clock <= #20 bus_clock;
  assign phase_shift_clock_bar = wr_q ? 1'b0 : ~phase_shift_clock;
  task automatic xfer(input logic rd, input int lat, input int n);
    logic [7:0] b;
    logic m;
    wr_q = !rd;
    #1.3 select_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      m = 1'($urandom);
      if (i == 0) b[CA_DIR_BIT] = rd;
      if (i < CA_BYTES) exp_ev.push_back({KIND_CA, 1'b0, b});
      else if (!rd && i >= CA_BYTES + lat) exp_ev.push_back({KIND_WR, m, b});
      else b = ~dq_host;
      dq_host = b;
      mask_out = m;
      #40 bus_clock = 1'b1;
      #40 bus_clock = 1'b0;
      if (rd && i >= CA_BYTES - 1 + lat) got_rd.push_back(dq_out);
    end
    select_b = 1'b1;
    dq_host = ~dq_host;
    #120;
  endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Self-checking bench of strobe_iface.
// Assumes: Host model frames all link traffic.
// Notes: Byte stream, read supply and error flag modelled here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import strobe_iface_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic opt = 1'b0;
  logic addl = 1'b0;
  logic ev_ready = 1'b0;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic ecc_event = 1'b0;
  logic err_clear = 1'b0;
  logic err_m = 1'b0;
  logic stall = 1'b0;
  logic live = 1'b0;
  logic [10:0] e;
  logic [10:0] g;
  logic [7:0] exp_rd[$];
  int fail_count = 0;
  int comparisons = 0;
  wire logic bus_clock, bus_clock_bar, phase_shift_clock, phase_shift_clock_bar, select_b;
  wire logic mask_out, dq_oe, rw_data_strobe_out, rw_data_strobe_oe, ev_valid, rd_ready, err_out;
  wire logic [7:0] dq_host, dq_out;
  wire logic [10:0] ev_data;
  wire logic [7:0] dq_wire = dq_oe ? dq_out : dq_host;
  wire logic ds_wire = rw_data_strobe_oe ? rw_data_strobe_out : mask_out;
  host_model host (.bus_clock, .bus_clock_bar, .phase_shift_clock, .phase_shift_clock_bar,
    .select_b, .dq_host, .mask_out, .dq_out);
  strobe_iface uut (.clk_sys, .rst_b, .bus_clock, .bus_clock_bar, .phase_shift_clock,
    .phase_shift_clock_bar, .select_b, .dq_in(dq_wire), .dq_out, .dq_oe,
    .rw_data_strobe_in(ds_wire), .rw_data_strobe_out, .rw_data_strobe_oe,
    .centered_read_strobe_option(opt), .addl_latency(addl), .ev_valid, .ev_ready, .ev_data,
    .rd_valid, .rd_ready, .rd_data, .ecc_event, .err_clear, .err_out);
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #2.5 clk_sys = ~clk_sys;
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  // Supply byte held steady through its fetch pulse
  always @(negedge clk_sys) begin
    ev_ready <= !stall && (($urandom % 4) != 0);
    ecc_event <= (($urandom % 64) == 0);
    err_clear <= (($urandom % 32) == 0);
    if (rd_ready) exp_rd.push_back(rd_valid ? rd_data : IDLE_BYTE);
    else begin
      rd_valid <= (($urandom % 8) != 0);
      rd_data <= 8'($urandom);
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_b) err_m = 1'b0;
    else begin
      chk(11'(err_out), 11'(err_m));
      err_m = ecc_event | (err_m & ~err_clear);
      if (ev_valid && ev_ready) begin
        e = host.exp_ev.size() > 0 ? host.exp_ev.pop_front() : 11'h7FF;
        g = ev_data;
        chk(g, e);
      end
    end
  end
  always @(negedge select_b) begin
    #2;
    if (live) chk(11'({rw_data_strobe_oe, rw_data_strobe_out}), 11'({1'b1, addl}));
  end
  initial begin
    void'($urandom(26));
    for (int o = 0; o < 2; o++) begin
      for (int f = 0; f < 2; f++) begin
        rst_b = 1'b0;
        live = 1'b0;
        opt = o[0];
        addl = f[0];
        repeat (8) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        // Short odd frame: flag crosses, and no false word may follow it
        host.xfer(1'b1, 0, 3);
        live = 1'b1;
        fork
          host.xfer(1'b0, LATENCY_CLOCKS * (f + 1), 16);
          begin
            #30 stall = f[0];
            #160 stall = 1'b0;
          end
        join
        exp_rd.delete();
        host.got_rd.delete();
        host.xfer(1'b1, LATENCY_CLOCKS * (f + 1), CA_BYTES + LATENCY_CLOCKS * (f + 1) + 4);
        foreach (host.got_rd[i]) chk(11'(host.got_rd[i]), 11'(exp_rd[i]));
      end
    end
    fork
      host.xfer(1'b1, 2 * LATENCY_CLOCKS, 30);
      begin
        #1400 chk(11'({dq_oe, rw_data_strobe_oe}), 11'h3);
        #1 rst_b = 1'b0;
        #1 chk(11'({dq_oe, rw_data_strobe_oe}), 11'h0);
      end
    join
    wrap_up();
  end
endmodule
`default_nettype wire
